// >>> common/sms_pkg.sv
// Constants, register map and carrier types for the supply mode sequencer.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package sms_pkg;

  // Register byte offsets
  localparam logic [7:0] SMS_ADDR_PROTECT = 8'h00;
  localparam logic [7:0] SMS_ADDR_CONTROL = 8'h04;
  localparam logic [7:0] SMS_ADDR_TIMING = 8'h08;
  localparam logic [7:0] SMS_ADDR_FLAG = 8'h0C;
  localparam logic [7:0] SMS_ADDR_MASK = 8'h10;
  localparam logic [7:0] SMS_ADDR_STATUS = 8'h14;

  // Decoded register selects
  localparam logic [2:0] SMS_SEL_NONE = 3'h0;
  localparam logic [2:0] SMS_SEL_PROTECT = 3'h1;
  localparam logic [2:0] SMS_SEL_CONTROL = 3'h2;
  localparam logic [2:0] SMS_SEL_TIMING = 3'h3;
  localparam logic [2:0] SMS_SEL_FLAG = 3'h4;
  localparam logic [2:0] SMS_SEL_MASK = 3'h5;
  localparam logic [2:0] SMS_SEL_STATUS = 3'h6;

  localparam logic [15:0] SMS_PROTECT_KEY = 16'h0096;
  localparam logic [15:0] SMS_PROTECT_RST = 16'h0000;

  // Mode field codes
  localparam logic [2:0] SMS_MODE_AUTO = 3'h0;
  localparam logic [2:0] SMS_MODE_NORMAL = 3'h2;
  localparam logic [2:0] SMS_MODE_ECONOMY = 3'h3;
  localparam logic [2:0] SMS_MODE_PUMP = 3'h5;
  localparam logic [2:0] SMS_MODE_RST = 3'h0;
  localparam logic [1:0] SMS_DIV_RST = 2'h0;

  // Field positions
  localparam int SMS_FLAG_DONE_BIT = 0;
  localparam int SMS_STAT_ECON_BIT = 0;
  localparam int SMS_STAT_PUMP_BIT = 1;
  localparam int SMS_STAT_PEND_BIT = 2;

  localparam logic [1:0] SMS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SMS_RESP_SLVERR = 2'h2;

  // Timing: 100 MHz clock, delays in microseconds (1000 us and 10000 us)
  localparam int SMS_CLK_HZ = 32'h05F5_E100;
  localparam int SMS_HZ_PER_MHZ = 32'h000F_4240;
  localparam int SMS_AUTO_DELAY_US = 32'h0000_03E8;
  localparam int SMS_EXIT_DELAY_US = 32'h0000_2710;
  localparam int SMS_AUTO_DELAY_CYC = SMS_CLK_HZ / SMS_HZ_PER_MHZ * SMS_AUTO_DELAY_US;
  localparam int SMS_EXIT_DELAY_CYC = SMS_CLK_HZ / SMS_HZ_PER_MHZ * SMS_EXIT_DELAY_US;

  typedef enum logic [1:0] {
    SMS_OP_NORMAL = 2'b00,
    SMS_OP_ECONOMY = 2'b01,
    SMS_OP_PUMP = 2'b10
  } sms_op_t;

  // Clock generator and CPU state seen by the sequencer
  typedef struct packed {
    logic fast_run;
    logic cpu_sleep;
    logic crystal_sleep_stop;
  } sms_clk_status_t;

  // Controls toward the regulator and charge pump
  typedef struct packed {
    logic economy_en;
    logic pump_en;
    logic [1:0] pump_div;
  } sms_supply_ctrl_t;

endpackage : sms_pkg

// >>> hw/sms_delay_timer.sv
// Restartable delay timer: pulses done once after run has been high LENGTH cycles.
// Assumes run is a synchronous level; dropping it restarts the count.
module sms_delay_timer #(
  parameter int WIDTH = 20,
  parameter int LENGTH = 100000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic done
);

  localparam logic [WIDTH-1:0] LEN_W = WIDTH'(LENGTH);
  localparam logic [WIDTH-1:0] ONE_W = WIDTH'(1);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic done_reg;
  logic done_next;

  if (LENGTH < 2 || LENGTH >= (2 ** WIDTH) - 1)
  begin : g_check
    $error("sms_delay_timer: LENGTH does not fit WIDTH");
  end

  always_comb
  begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (!run)
    begin
      cnt_next = '0;
    end
    else if (cnt_reg != LEN_W)
    begin
      cnt_next = cnt_reg + ONE_W;
      // Saturating at LENGTH keeps the pulse single while run stays high
      done_next = (cnt_reg == LEN_W - ONE_W);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;

endmodule : sms_delay_timer

// >>> hw/sms_sequencer.sv
// Supply mode sequencer: key-protected mode register, automatic normal/economy
// switching, super economy exit delay and the transition-done interrupt.
// Assumes an AXI4-Lite master on CLK and clock/CPU status synchronous to CLK.
module sms_sequencer #(
  parameter int AUTO_DELAY_CYC = sms_pkg::SMS_AUTO_DELAY_CYC,
  parameter int EXIT_DELAY_CYC = sms_pkg::SMS_EXIT_DELAY_CYC,
  parameter int TIMER_WIDTH = 20
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire sms_pkg::sms_clk_status_t CLK_STATUS,
  output sms_pkg::sms_supply_ctrl_t SUPPLY_CTRL,
  output logic IRQ
);

  function automatic logic [2:0] sms_decode(input logic [7:0] a);
    if (a == sms_pkg::SMS_ADDR_PROTECT) return sms_pkg::SMS_SEL_PROTECT;
    else if (a == sms_pkg::SMS_ADDR_CONTROL) return sms_pkg::SMS_SEL_CONTROL;
    else if (a == sms_pkg::SMS_ADDR_TIMING) return sms_pkg::SMS_SEL_TIMING;
    else if (a == sms_pkg::SMS_ADDR_FLAG) return sms_pkg::SMS_SEL_FLAG;
    else if (a == sms_pkg::SMS_ADDR_MASK) return sms_pkg::SMS_SEL_MASK;
    else if (a == sms_pkg::SMS_ADDR_STATUS) return sms_pkg::SMS_SEL_STATUS;
    else return sms_pkg::SMS_SEL_NONE;
  endfunction : sms_decode

  function automatic logic sms_legal(input logic [2:0] m);
    return m == sms_pkg::SMS_MODE_AUTO || m == sms_pkg::SMS_MODE_NORMAL ||
           m == sms_pkg::SMS_MODE_ECONOMY || m == sms_pkg::SMS_MODE_PUMP;
  endfunction : sms_legal

  if (AUTO_DELAY_CYC < 2 || EXIT_DELAY_CYC < 2 || TIMER_WIDTH > 31)
  begin : g_check
    $error("sms_sequencer: delay parameters out of range");
  end

  // Bus state
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  // Block state
  logic [15:0] key_reg, key_next;
  logic [2:0] mode_reg, mode_next;
  logic [1:0] div_reg, div_next;
  logic flag_reg, flag_next, mask_reg, mask_next, pend_reg, pend_next;
  logic sleep_prev_reg, irq_reg, irq_next;
  sms_pkg::sms_op_t op_reg, op_next;
  sms_pkg::sms_supply_ctrl_t ctrl_reg, ctrl_next;
  // Helpers
  logic wr_fire, ar_take, sleep_entry, wake, auto_mode, auto_run, auto_done, exit_done;
  logic flag_clr, mode_wr_ok;
  logic [2:0] wr_sel;

  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_sel = sms_decode(aw_addr_reg);
  assign ar_take = ARVALID && arready_reg;
  assign sleep_entry = CLK_STATUS.cpu_sleep && !sleep_prev_reg;
  assign wake = !CLK_STATUS.cpu_sleep && sleep_prev_reg;
  assign auto_mode = mode_reg == sms_pkg::SMS_MODE_AUTO;
  // Runs in automatic normal operation while only the crystal is left, awake or asleep, except on a crystal-stopping sleep entry
  assign auto_run = auto_mode && op_reg == sms_pkg::SMS_OP_NORMAL &&
                    !CLK_STATUS.fast_run && !(sleep_entry && CLK_STATUS.crystal_sleep_stop);
  assign flag_clr = wr_fire && wr_sel == sms_pkg::SMS_SEL_FLAG &&
                    w_strb_reg[0] && w_data_reg[sms_pkg::SMS_FLAG_DONE_BIT];
  assign mode_wr_ok = wr_fire && wr_sel == sms_pkg::SMS_SEL_CONTROL && w_strb_reg[0] &&
                      key_reg == sms_pkg::SMS_PROTECT_KEY && sms_legal(w_data_reg[2:0]);

  sms_delay_timer #(.WIDTH(TIMER_WIDTH), .LENGTH(AUTO_DELAY_CYC)) u_auto_timer (
    .clk(CLK),
    .rst(RST),
    .run(auto_run),
    .done(auto_done)
  );

  sms_delay_timer #(.WIDTH(TIMER_WIDTH), .LENGTH(EXIT_DELAY_CYC)) u_exit_timer (
    .clk(CLK),
    .rst(RST),
    .run(pend_reg),
    .done(exit_done)
  );

  // Bus channels
  always_comb
  begin
    aw_have_next = aw_have_reg && !wr_fire;
    aw_addr_next = aw_addr_reg;
    if (AWVALID && awready_reg)
    begin
      aw_have_next = 1'b1;
      aw_addr_next = AWADDR;
    end
    w_have_next = w_have_reg && !wr_fire;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    if (WVALID && wready_reg)
    begin
      w_have_next = 1'b1;
      w_data_next = WDATA;
      w_strb_next = WSTRB;
    end
    awready_next = !aw_have_next;
    wready_next = !w_have_next;
    bvalid_next = bvalid_reg && !BREADY;
    bresp_next = bresp_reg;
    if (wr_fire)
    begin
      bvalid_next = 1'b1;
      bresp_next = (wr_sel == sms_pkg::SMS_SEL_NONE) ? sms_pkg::SMS_RESP_SLVERR
                                                    : sms_pkg::SMS_RESP_OKAY;
    end
    rvalid_next = rvalid_reg && !RREADY;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take)
    begin
      rvalid_next = 1'b1;
      rresp_next = sms_pkg::SMS_RESP_OKAY;
      rdata_next = '0;
      case (sms_decode(ARADDR))
        sms_pkg::SMS_SEL_PROTECT: rdata_next[15:0] = key_reg;
        sms_pkg::SMS_SEL_CONTROL: rdata_next[2:0] = mode_reg;
        sms_pkg::SMS_SEL_TIMING: rdata_next[1:0] = div_reg;
        sms_pkg::SMS_SEL_FLAG: rdata_next[sms_pkg::SMS_FLAG_DONE_BIT] = flag_reg;
        sms_pkg::SMS_SEL_MASK: rdata_next[sms_pkg::SMS_FLAG_DONE_BIT] = mask_reg;
        sms_pkg::SMS_SEL_STATUS:
        begin
          rdata_next[sms_pkg::SMS_STAT_ECON_BIT] = op_reg == sms_pkg::SMS_OP_ECONOMY;
          rdata_next[sms_pkg::SMS_STAT_PUMP_BIT] = op_reg == sms_pkg::SMS_OP_PUMP;
          rdata_next[sms_pkg::SMS_STAT_PEND_BIT] = pend_reg;
        end
        default: rresp_next = sms_pkg::SMS_RESP_SLVERR;
      endcase
    end
    arready_next = !rvalid_next;
  end

  // Registers and mode sequencing
  always_comb
  begin
    key_next = key_reg;
    mode_next = mode_reg;
    div_next = div_reg;
    mask_next = mask_reg;
    if (wr_fire && wr_sel == sms_pkg::SMS_SEL_PROTECT)
      key_next = {w_strb_reg[1] ? w_data_reg[15:8] : key_reg[15:8],
                  w_strb_reg[0] ? w_data_reg[7:0] : key_reg[7:0]};
    if (wr_fire && wr_sel == sms_pkg::SMS_SEL_TIMING && w_strb_reg[0]) div_next = w_data_reg[1:0];
    if (wr_fire && wr_sel == sms_pkg::SMS_SEL_MASK && w_strb_reg[0])
      mask_next = w_data_reg[sms_pkg::SMS_FLAG_DONE_BIT];
    if (mode_wr_ok) mode_next = w_data_reg[2:0];
    pend_next = pend_reg && !exit_done;
    if (mode_next != mode_reg && mode_reg == sms_pkg::SMS_MODE_PUMP &&
        (mode_next == sms_pkg::SMS_MODE_AUTO || mode_next == sms_pkg::SMS_MODE_ECONOMY))
      pend_next = 1'b1;
    if (mode_next == sms_pkg::SMS_MODE_PUMP) pend_next = 1'b0;
    op_next = op_reg;
    case (mode_reg)
      sms_pkg::SMS_MODE_NORMAL: op_next = sms_pkg::SMS_OP_NORMAL;
      sms_pkg::SMS_MODE_ECONOMY: op_next = sms_pkg::SMS_OP_ECONOMY;
      sms_pkg::SMS_MODE_PUMP: op_next = sms_pkg::SMS_OP_PUMP;
      default:
      begin
        // Automatic mode; a pump exit lands in economy until a fast clock appears
        if (op_reg == sms_pkg::SMS_OP_PUMP) op_next = sms_pkg::SMS_OP_ECONOMY;
        else if (wake) op_next = CLK_STATUS.fast_run ? sms_pkg::SMS_OP_NORMAL
                                                     : sms_pkg::SMS_OP_ECONOMY;
        else if (op_reg == sms_pkg::SMS_OP_ECONOMY && CLK_STATUS.fast_run)
          op_next = sms_pkg::SMS_OP_NORMAL;
        else if (op_reg == sms_pkg::SMS_OP_NORMAL && sleep_entry &&
                 CLK_STATUS.crystal_sleep_stop)
          op_next = sms_pkg::SMS_OP_ECONOMY;
        else if (op_reg == sms_pkg::SMS_OP_NORMAL && auto_done && !CLK_STATUS.fast_run)
          op_next = sms_pkg::SMS_OP_ECONOMY;
      end
    endcase
    // Hardware set wins over a software clear in the same cycle
    flag_next = (flag_reg && !flag_clr) || exit_done ||
                (auto_mode && op_reg == sms_pkg::SMS_OP_NORMAL && auto_done &&
                 !CLK_STATUS.fast_run);
    irq_next = flag_next && mask_next;
    ctrl_next.economy_en = op_next == sms_pkg::SMS_OP_ECONOMY;
    ctrl_next.pump_en = op_next == sms_pkg::SMS_OP_PUMP;
    ctrl_next.pump_div = div_next;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= sms_pkg::SMS_RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= sms_pkg::SMS_RESP_OKAY;
      key_reg <= sms_pkg::SMS_PROTECT_RST;
      mode_reg <= sms_pkg::SMS_MODE_RST;
      div_reg <= sms_pkg::SMS_DIV_RST;
      flag_reg <= 1'b0;
      mask_reg <= 1'b0;
      pend_reg <= 1'b0;
      sleep_prev_reg <= 1'b0;
      irq_reg <= 1'b0;
      op_reg <= sms_pkg::SMS_OP_NORMAL;
      ctrl_reg <= '0;
    end
    else
    begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      key_reg <= key_next;
      mode_reg <= mode_next;
      div_reg <= div_next;
      flag_reg <= flag_next;
      mask_reg <= mask_next;
      pend_reg <= pend_next;
      sleep_prev_reg <= CLK_STATUS.cpu_sleep;
      irq_reg <= irq_next;
      op_reg <= op_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign AWREADY = awready_reg;
  assign WREADY = wready_reg;
  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;
  assign ARREADY = arready_reg;
  assign RVALID = rvalid_reg;
  assign RDATA = rdata_reg;
  assign RRESP = rresp_reg;
  assign SUPPLY_CTRL = ctrl_reg;
  assign IRQ = irq_reg;

  default clocking cb_seq @(posedge CLK); endclocking
  default disable iff (RST);
  property p_key_lock;
    (wr_fire && wr_sel == sms_pkg::SMS_SEL_CONTROL && key_reg != sms_pkg::SMS_PROTECT_KEY)
      |=> mode_reg == $past(mode_reg);
  endproperty
  a_key_lock: assert property (p_key_lock) else $error("Mode changed while locked");
  property p_economy_code;
    (mode_reg == sms_pkg::SMS_MODE_ECONOMY && $stable(mode_reg))
      |=> SUPPLY_CTRL.economy_en && !SUPPLY_CTRL.pump_en;
  endproperty
  a_economy_code: assert property (p_economy_code) else $error("Economy code ignored");
  property p_pump_code;
    mode_reg == sms_pkg::SMS_MODE_PUMP |=> op_reg == sms_pkg::SMS_OP_PUMP && SUPPLY_CTRL.pump_en;
  endproperty
  a_pump_code: assert property (p_pump_code) else $error("Pump not enabled");
  property p_auto_timeout;
    (auto_mode && op_reg == sms_pkg::SMS_OP_NORMAL && auto_done && !CLK_STATUS.fast_run && !wake)
      |=> op_reg == sms_pkg::SMS_OP_ECONOMY && flag_reg;
  endproperty
  a_auto_timeout: assert property (p_auto_timeout) else $error("No economy after delay");
  property p_fast_start;
    (auto_mode && op_reg == sms_pkg::SMS_OP_ECONOMY && CLK_STATUS.fast_run)
      |=> op_reg == sms_pkg::SMS_OP_NORMAL && !SUPPLY_CTRL.economy_en;
  endproperty
  a_fast_start: assert property (p_fast_start) else $error("Fast clock kept economy");
  property p_sleep_stop;
    (auto_mode && op_reg == sms_pkg::SMS_OP_NORMAL && sleep_entry &&
     CLK_STATUS.crystal_sleep_stop && !exit_done)
      |=> op_reg == sms_pkg::SMS_OP_ECONOMY && !$rose(flag_reg);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("Sleep entry mishandled");
  property p_wake;
    (auto_mode && op_reg != sms_pkg::SMS_OP_PUMP && wake)
      |=> op_reg == ($past(CLK_STATUS.fast_run) ? sms_pkg::SMS_OP_NORMAL
                                                : sms_pkg::SMS_OP_ECONOMY);
  endproperty
  a_wake: assert property (p_wake) else $error("Wrong mode on wake");
  property p_exit_flag;
    exit_done |=> flag_reg ##0 !pend_reg;
  endproperty
  a_exit_flag: assert property (p_exit_flag) else $error("Exit delay flag missing");
  property p_sticky;
    (flag_reg && !flag_clr) |=> flag_reg && IRQ == mask_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("Flag or interrupt lost");

endmodule : sms_sequencer

// >>> sim/sms_sequencer_test.sv
// Self-checking bench for the supply mode sequencer, driving AXI4-Lite and clock status.
// Assumes the design's own assertions and the shortened delays set below.
module sms_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AUTO = 20;
  localparam int EXIT = 50;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] AWADDR = 8'h00;
  logic AWVALID = 1'b0;
  logic AWREADY;
  logic [31:0] WDATA = 32'h0000_0000;
  logic [3:0] WSTRB = 4'hF;
  logic WVALID = 1'b0;
  logic WREADY;
  logic [1:0] BRESP;
  logic BVALID;
  logic BREADY = 1'b0;
  logic [7:0] ARADDR = 8'h00;
  logic ARVALID = 1'b0;
  logic ARREADY;
  logic [31:0] RDATA;
  logic [1:0] RRESP;
  logic RVALID;
  logic RREADY = 1'b0;
  sms_pkg::sms_clk_status_t CLK_STATUS = 3'b100;
  sms_pkg::sms_supply_ctrl_t SUPPLY_CTRL;
  logic IRQ;
  logic [33:0] exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 32'h5829_0792;
  logic [31:0] rnd;
  logic [2:0] codes [3] = '{3'h2, 3'h3, 3'h5};
  logic [2:0] exits [2] = '{3'h3, 3'h0};

  always #5 CLK = ~CLK;

  sms_sequencer #(.AUTO_DELAY_CYC(AUTO), .EXIT_DELAY_CYC(EXIT), .TIMER_WIDTH(20)) uut (
    .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .CLK_STATUS(CLK_STATUS), .SUPPLY_CTRL(SUPPLY_CTRL), .IRQ(IRQ));

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic take(input logic [33:0] got);
    if (exp_q.size() == 0)
    begin
      error_cnt++;
      $display("ERROR at %0t: unexpected bus response", $time);
    end
    else
      cmp(got, exp_q.pop_front(), "bus response");
  endtask : take

  // Bus answers are compared here, against the oldest noted expectation
  always @(posedge CLK)
  begin
    if (BVALID === 1'b1 && BREADY === 1'b1)
      take({BRESP, 32'h0000_0000});
    if (RVALID === 1'b1 && RREADY === 1'b1)
      take({RRESP, RDATA});
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = sms_pkg::SMS_RESP_OKAY);
    exp_q.push_back({r, 32'h0000_0000});
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do
    begin
      @(posedge CLK);
      if (AWREADY === 1'b1)
        AWVALID <= 1'b0;
      if (WREADY === 1'b1)
        WVALID <= 1'b0;
    end
    while (BVALID !== 1'b1);
    BREADY <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = sms_pkg::SMS_RESP_OKAY);
    exp_q.push_back({r, d});
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do
    begin
      @(posedge CLK);
      if (ARREADY === 1'b1)
        ARVALID <= 1'b0;
    end
    while (RVALID !== 1'b1);
    RREADY <= 1'b0;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc

  // Fields: fast_run, cpu_sleep, crystal_sleep_stop
  task automatic cs(input logic [2:0] v);
    @(posedge CLK);
    CLK_STATUS <= v;
  endtask : cs

  task automatic sup(input logic e, input logic p);
    cmp({32'h0000_0000, SUPPLY_CTRL.economy_en, SUPPLY_CTRL.pump_en}, {32'h0000_0000, e, p},
        "supply enables");
  endtask : sup

  task automatic irq_is(input logic v);
    cmp({33'h0_0000_0000, IRQ}, {33'h0_0000_0000, v}, "interrupt");
  endtask : irq_is

  task automatic done_test(input string name);
    $display("test %s finished", name);
  endtask : done_test

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // Whole sequence needs a few hundred cycles; this leaves ample margin
  initial
  begin
    repeat (20000) @(posedge CLK);
    error_cnt++;
    $display("ERROR at %0t: watchdog expired", $time);
    finish_test;
  end

  initial
  begin
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    sup(1'b0, 1'b0);
    irq_is(1'b0);
    for (int i = 0; i < 6; i++)
      rd(8'(i * 4), 32'h0000_0000);
    rd(8'h18, 32'h0000_0000, sms_pkg::SMS_RESP_SLVERR);
    wr(8'h18, 32'hFFFF_FFFF, sms_pkg::SMS_RESP_SLVERR);
    done_test("reset");
    wr(sms_pkg::SMS_ADDR_CONTROL, 32'h0000_0003);
    rd(sms_pkg::SMS_ADDR_CONTROL, 32'h0000_0000);
    wr(sms_pkg::SMS_ADDR_PROTECT, 32'h0000_0096);
    wr(sms_pkg::SMS_ADDR_CONTROL, 32'h0000_0007);
    rd(sms_pkg::SMS_ADDR_CONTROL, 32'h0000_0000);
    rnd = $random(seed);
    wr(sms_pkg::SMS_ADDR_TIMING, rnd);
    rd(sms_pkg::SMS_ADDR_TIMING, {30'h0000_0000, rnd[1:0]});
    cs(3'b000);
    foreach (codes[i])
    begin
      wr(sms_pkg::SMS_ADDR_CONTROL, {29'h0000_0000, codes[i]});
      cyc(3);
      sup(codes[i] == 3'h3, codes[i] == 3'h5);
      rd(sms_pkg::SMS_ADDR_CONTROL, {29'h0000_0000, codes[i]});
      rd(sms_pkg::SMS_ADDR_STATUS, {30'h0000_0000, codes[i] == 3'h5, codes[i] == 3'h3});
    end
    cs(3'b010);
    cyc(3);
    sup(1'b0, 1'b1);
    cs(3'b000);
    cmp({32'h0000_0000, SUPPLY_CTRL.pump_div}, {32'h0000_0000, rnd[1:0]}, "divider");
    done_test("codes");
    wr(sms_pkg::SMS_ADDR_MASK, 32'h0000_0001);
    foreach (exits[i])
    begin
      wr(sms_pkg::SMS_ADDR_FLAG, 32'h0000_0001);
      wr(sms_pkg::SMS_ADDR_CONTROL, 32'h0000_0005);
      cyc(3);
      wr(sms_pkg::SMS_ADDR_CONTROL, {29'h0000_0000, exits[i]});
      rd(sms_pkg::SMS_ADDR_STATUS, 32'h0000_0005);
      cyc(EXIT - 12);
      rd(sms_pkg::SMS_ADDR_FLAG, 32'h0000_0000);
      cyc(20);
      rd(sms_pkg::SMS_ADDR_FLAG, 32'h0000_0001);
      irq_is(1'b1);
    end
    wr(sms_pkg::SMS_ADDR_MASK, 32'h0000_0000);
    cyc(2);
    irq_is(1'b0);
    rd(sms_pkg::SMS_ADDR_FLAG, 32'h0000_0001);
    wr(sms_pkg::SMS_ADDR_MASK, 32'h0000_0001);
    wr(sms_pkg::SMS_ADDR_FLAG, 32'h0000_0001);
    cyc(2);
    irq_is(1'b0);
    done_test("exit and flag");
    cs(3'b100);
    cyc(3);
    sup(1'b0, 1'b0);
    cs(3'b000);
    cyc(AUTO - 5);
    sup(1'b0, 1'b0);
    cyc(12);
    sup(1'b1, 1'b0);
    rd(sms_pkg::SMS_ADDR_FLAG, 32'h0000_0001);
    wr(sms_pkg::SMS_ADDR_FLAG, 32'h0000_0001);
    cs(3'b100);
    cyc(3);
    cs(3'b011);
    cyc(3);
    sup(1'b1, 1'b0);
    cyc(AUTO + 5);
    rd(sms_pkg::SMS_ADDR_FLAG, 32'h0000_0000);
    cs(3'b001);
    cyc(3);
    sup(1'b1, 1'b0);
    cs(3'b010);
    cyc(2);
    cs(3'b100);
    cyc(3);
    sup(1'b0, 1'b0);
    done_test("automatic");
    cs(3'b010);
    cyc(AUTO - 5);
    sup(1'b0, 1'b0);
    cyc(12);
    sup(1'b1, 1'b0);
    rd(sms_pkg::SMS_ADDR_FLAG, 32'h0000_0001);
    irq_is(1'b1);
    rnd = $random(seed);
    rnd[15:0] = (rnd[15:0] == 16'h0096) ? 16'h0097 : rnd[15:0];
    wr(sms_pkg::SMS_ADDR_PROTECT, rnd);
    wr(sms_pkg::SMS_ADDR_CONTROL, 32'h0000_0002);
    rd(sms_pkg::SMS_ADDR_CONTROL, 32'h0000_0000);
    done_test("sleep and relock");
    finish_test;
  end
endmodule : sms_sequencer_test
